// ### flash_prot_pkg.sv
// Package: register map, field layout and types for the flash program/erase protection block
package flash_prot_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL_ONE   = 8'h00;
  localparam logic [7:0] OFF_CTRL_TWO   = 8'h04;
  localparam logic [7:0] OFF_ERASE_SEL  = 8'h08;
  localparam logic [7:0] OFF_STATUS     = 8'h0C;

  // ----------------------------------------
  // Field positions of flash_control_one
  // ----------------------------------------
  localparam int unsigned BIT_PROG    = 0;
  localparam int unsigned BIT_ERASE   = 1;
  localparam int unsigned BIT_WR_EN   = 6;

  // Field positions of flash_control_two and status
  localparam int unsigned BIT_ERR_FLG = 7;
  localparam int unsigned BIT_ST_PROG = 0;
  localparam int unsigned BIT_ST_ERS  = 1;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CTRL_ONE  = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO  = 8'h00;
  localparam logic [7:0] RST_ERASE_SEL = 8'h00;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // Operating mode of the flash array
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_PROG  = 3'b010,
    ST_ERASE = 3'b100
  } flash_mode_t;

  // Events from the CPU that end a program/erase cycle
  typedef struct packed {
    logic flash_read;
    logic exception;
    logic sleep_exec;
    logic runaway;
    logic algo_fault;
  } prot_event_t;

  // Power-mode entries that force hardware protection
  typedef struct packed {
    logic subsleep;
    logic standby;
  } power_entry_t;

endpackage

// ### flash_prot.sv
// Flash program/erase protection logic with AHB-Lite register slave
//
// Contract
// RL1 - Reset, subsleep, standby abort program/erase
// RL2 - Those entries reinitialize all flash registers
// RL3 - Reset pin held low until oscillator stable (no oscillator check here; hresetn is used as driven)
// RL4 - Write enable cleared protects every block
// RL5 - Program/erase bits ignored under software protection
// RL6 - Per-block erase enable; zero protects all
// RL7 - Protection error sets flag and aborts
// RL8 - Flash read during operation is error
// RL9 - Non-reset exception during operation is error
// RL10 - Sleep during operation is error
// RL11 - Runaway or algorithm fault aborts operation
// RL12 - Error flag sticks until reinitialization
//
// Implementation choices: the AHB-Lite register port and the address map.
module flash_prot
  import flash_prot_pkg::*;
#(
  parameter int unsigned NUM_BLOCKS = 8
) (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Chip mode and CPU events
  input  wire power_entry_t          power_entry,
  input  wire prot_event_t           cpu_event,
  // Flash array control
  output logic                       flash_program_q,
  output logic                       flash_erase_q,
  output logic      [NUM_BLOCKS-1:0] flash_erase_blocks_q,
  output logic                       flash_error_flag_q
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (NUM_BLOCKS < 1 || NUM_BLOCKS > 8) begin : g_bad_blocks
    $error("NUM_BLOCKS must be 1 to 8");
  end

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;

  wire        addr_take  = hsel && hready && htrans == HTRANS_NONSEQ;
  wire        wr_take    = addr_take && hwrite && hsize == HSIZE_WORD;
  wire [7:0]  rd_addr    = haddr[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_take;
      wr_addr_q <= haddr[7:0];
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic                  wr_en_q;
  logic                  p_bit_q;
  logic                  e_bit_q;
  logic [NUM_BLOCKS-1:0] ebr_q;
  logic                  err_flag_q;
  flash_mode_t           mode_q;
  flash_mode_t           mode_d;

  // Power entries act as a synchronous clear so the registers are rebuilt
  // in the same edge as the abort
  wire power_hit = power_entry.subsleep || power_entry.standby;    // RL1
  wire busy      = mode_q != ST_IDLE;

  // Any CPU event counts only while an operation runs
  wire prot_err  = busy && (cpu_event.flash_read                   // RL8
                         || cpu_event.exception                    // RL9
                         || cpu_event.sleep_exec                   // RL10
                         || cpu_event.runaway                      // RL11
                         || cpu_event.algo_fault);                 // RL11

  wire wr_one    = wr_pend_q && wr_addr_q == OFF_CTRL_ONE;
  wire wr_ebr    = wr_pend_q && wr_addr_q == OFF_ERASE_SEL;

  wire wr_en_d   = wr_one ? hwdata[BIT_WR_EN] : wr_en_q;
  wire p_bit_d   = wr_one ? hwdata[BIT_PROG]  : p_bit_q;
  wire e_bit_d   = wr_one ? hwdata[BIT_ERASE] : e_bit_q;
  wire ebr_zero  = ebr_q == '0;

  // Entry needs write enable, no stuck error and, for erase, a chosen block
  wire can_prog  = wr_en_q && !err_flag_q;                         // RL4 RL5 RL12
  wire can_erase = can_prog && !ebr_zero;                          // RL6

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      ST_IDLE: begin
        if (prot_err) begin
          mode_d = ST_IDLE;
        end else if (p_bit_q && can_prog) begin
          mode_d = ST_PROG;
        end else if (e_bit_q && can_erase) begin
          mode_d = ST_ERASE;
        end
      end
      ST_PROG: begin
        if (prot_err || !p_bit_q || !wr_en_q) begin                // RL7
          mode_d = ST_IDLE;
        end
      end
      ST_ERASE: begin
        if (prot_err || !e_bit_q || !wr_en_q) begin                // RL7
          mode_d = ST_IDLE;
        end
      end
      default: begin
        mode_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_en_q    <= RST_CTRL_ONE[BIT_WR_EN];
      p_bit_q    <= RST_CTRL_ONE[BIT_PROG];
      e_bit_q    <= RST_CTRL_ONE[BIT_ERASE];
      ebr_q      <= RST_ERASE_SEL[NUM_BLOCKS-1:0];
      err_flag_q <= RST_CTRL_TWO[BIT_ERR_FLG];
      mode_q     <= ST_IDLE;
    end else if (power_hit) begin                                  // RL1 RL2
      wr_en_q    <= RST_CTRL_ONE[BIT_WR_EN];
      p_bit_q    <= RST_CTRL_ONE[BIT_PROG];
      e_bit_q    <= RST_CTRL_ONE[BIT_ERASE];
      ebr_q      <= RST_ERASE_SEL[NUM_BLOCKS-1:0];
      err_flag_q <= RST_CTRL_TWO[BIT_ERR_FLG];
      mode_q     <= ST_IDLE;
    end else begin
      wr_en_q    <= wr_en_d;
      p_bit_q    <= p_bit_d;
      e_bit_q    <= e_bit_d;
      if (wr_ebr) begin
        ebr_q <= hwdata[NUM_BLOCKS-1:0];
      end
      // Flag is read-only to software and never cleared here
      err_flag_q <= err_flag_q || prot_err;                        // RL7 RL12
      mode_q  <= mode_d;
    end
  end

  // ----------------------------------------
  // Outputs and read data
  // ----------------------------------------
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (rd_addr)
      OFF_CTRL_ONE: begin
        rdata_d[BIT_WR_EN] = wr_en_q;
        rdata_d[BIT_PROG]  = p_bit_q;
        rdata_d[BIT_ERASE] = e_bit_q;
      end
      OFF_CTRL_TWO: begin
        rdata_d[BIT_ERR_FLG] = err_flag_q;
      end
      OFF_ERASE_SEL: begin
        rdata_d[NUM_BLOCKS-1:0] = ebr_q;
      end
      OFF_STATUS: begin
        rdata_d[BIT_ST_PROG] = mode_q == ST_PROG;
        rdata_d[BIT_ST_ERS]  = mode_q == ST_ERASE;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata               <= 32'h0000_0000;
      hreadyout            <= 1'b1;
      hresp                <= 1'b0;
      flash_program_q      <= 1'b0;
      flash_erase_q        <= 1'b0;
      flash_erase_blocks_q <= '0;
      flash_error_flag_q   <= 1'b0;
    end else begin
      if (addr_take && !hwrite) begin
        hrdata <= rdata_d;
      end
      hreadyout            <= 1'b1;
      hresp                <= 1'b0;
      flash_program_q      <= mode_d == ST_PROG && !power_hit;     // RL1
      flash_erase_q        <= mode_d == ST_ERASE && !power_hit;    // RL1
      flash_erase_blocks_q <= power_hit ? '0 : ebr_q;              // RL6
      flash_error_flag_q   <= !power_hit && (err_flag_q || prot_err);  // RL7
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_power_abort;
    @(posedge hclk) disable iff (!hresetn)
      power_hit |=> !flash_program_q && !flash_erase_q;
  endproperty
  a_power_abort: assert property (p_power_abort) else $error("operation survived power entry"); // RL1

  property p_power_init;
    @(posedge hclk) disable iff (!hresetn)
      power_hit |=> !wr_en_q && !err_flag_q && ebr_q == '0 && !p_bit_q && !e_bit_q;
  endproperty
  a_power_init: assert property (p_power_init) else $error("registers not reinitialized"); // RL2

  property p_wr_en_guard;
    @(posedge hclk) disable iff (!hresetn)
      !wr_en_q |=> !flash_program_q && !flash_erase_q;
  endproperty
  a_wr_en_guard: assert property (p_wr_en_guard) else $error("operation without write enable"); // RL4

  property p_no_entry;
    @(posedge hclk) disable iff (!hresetn)
      (mode_q == ST_IDLE && !wr_en_q) |=> mode_q == ST_IDLE;
  endproperty
  a_no_entry: assert property (p_no_entry) else $error("mode entered under protection"); // RL5

  property p_ebr_zero;
    @(posedge hclk) disable iff (!hresetn)
      (mode_q == ST_IDLE && ebr_zero) |=> mode_q != ST_ERASE;
  endproperty
  a_ebr_zero: assert property (p_ebr_zero) else $error("erase with no block"); // RL6

  property p_err_set;
    @(posedge hclk) disable iff (!hresetn)
      (prot_err && !power_hit) |=> err_flag_q && flash_error_flag_q && mode_q == ST_IDLE;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error not flagged or not aborted"); // RL7

  property p_read_err;
    @(posedge hclk) disable iff (!hresetn)
      (busy && cpu_event.flash_read && !power_hit) |=> err_flag_q;
  endproperty
  a_read_err: assert property (p_read_err) else $error("flash read not caught"); // RL8

  property p_sleep_err;
    @(posedge hclk) disable iff (!hresetn)
      (busy && (cpu_event.sleep_exec || cpu_event.exception) && !power_hit) |=> !flash_program_q && !flash_erase_q;
  endproperty
  a_sleep_err: assert property (p_sleep_err) else $error("sleep or exception not aborted"); // RL9 RL10

  property p_sticky;
    @(posedge hclk) disable iff (!hresetn)
      (err_flag_q && !power_hit) |=> err_flag_q && mode_q == ST_IDLE;
  endproperty
  a_sticky: assert property (p_sticky) else $error("error flag lost"); // RL12

  c_prog: cover property (@(posedge hclk) disable iff (!hresetn) mode_q == ST_PROG);
  c_erase: cover property (@(posedge hclk) disable iff (!hresetn) mode_q == ST_ERASE);
  c_error: cover property (@(posedge hclk) disable iff (!hresetn) busy ##1 err_flag_q);
  c_power: cover property (@(posedge hclk) disable iff (!hresetn) busy && power_hit);

endmodule

// ### cpu_bus_model.sv
// CPU side model: AHB-Lite master and source of CPU events
module cpu_bus_model
  import flash_prot_pkg::*;
(
  // Clock and bus answer
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Bus request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // CPU events
  output prot_event_t      cpu_event
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {hsel, haddr, htrans, hwrite, hsize, hwdata, cpu_event} = '0;
  end

  // One single word transfer; released address and data lines show inverted values, not stale ones
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    haddr  <= ~{24'h0, a};
    hwdata <= wr ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~hwdata;
  endtask

  // Event held for exactly one cycle
  task automatic pulse(input prot_event_t e);
    @(posedge hclk);
    cpu_event <= e;
    @(posedge hclk);
    cpu_event <= '0;
  endtask
endmodule

// ### testbench.sv
// Self-checking bench for the flash program/erase protection block
module testbench
  import flash_prot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  power_entry_t power_entry = '0;
  logic         hsel, hwrite, hreadyout, hresp, prog_q, erase_q, err_flag, fl_e;
  logic [31:0]  haddr, hwdata, hrdata, rd;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [7:0]   blocks_q, c1, sel;
  prot_event_t  cpu_event;
  int           err_total = 0;
  int           checks_done = 0;
  int           cycles = 0;

  always #5 hclk = ~hclk;

  flash_prot #(.NUM_BLOCKS(8)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .power_entry(power_entry),
    .cpu_event(cpu_event), .flash_program_q(prog_q), .flash_erase_q(erase_q),
    .flash_erase_blocks_q(blocks_q), .flash_error_flag_q(err_flag));

  cpu_bus_model cpu (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .cpu_event(cpu_event));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic stop_test;
    $display("Checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run needs well under this many cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    cpu.xfer(1'b0, a, 32'h0, rd);
    chk(name, exp, rd);
    chk("resp", 32'h0, {31'h0, hresp});
  endtask

  task automatic settle;
    repeat (2) @(posedge hclk);
    #1;
  endtask

  // Entry needs write enable and a clear flag; program wins, erase needs a selected block
  function automatic logic [1:0] exp_mode(input logic [7:0] c, input logic [7:0] s, input logic fl);
    logic ok;
    ok = c[BIT_WR_EN] && !fl;
    exp_mode = {ok && c[BIT_PROG], ok && !c[BIT_PROG] && c[BIT_ERASE] && (s != 8'h00)};
  endfunction

  task automatic apply(input logic [7:0] c, input logic [7:0] s);
    logic [1:0] m;
    m = exp_mode(c, s, fl_e);
    wr(OFF_CTRL_ONE, 32'h0);
    wr(OFF_ERASE_SEL, {24'h0, s});
    wr(OFF_CTRL_ONE, {24'h0, c});
    settle();
    chk("mode", {30'h0, m}, {30'h0, prog_q, erase_q});
    chk("blocks", {24'h0, s}, {24'h0, blocks_q});
    rdchk("status", OFF_STATUS, {30'h0, m[0], m[1]});
  endtask

  task automatic regs_clear;
    rdchk("ctrl_one", OFF_CTRL_ONE, 32'h0);
    rdchk("ctrl_two", OFF_CTRL_TWO, 32'h0);
    rdchk("erase_sel", OFF_ERASE_SEL, 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] tbl [4];
    tbl = '{8'h42, 8'h42, 8'h01, 8'h03};
    fl_e = 1'b0;
    void'($urandom(32'hC65153F5));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    regs_clear();
    wr(OFF_CTRL_TWO, 32'h80);
    wr(OFF_STATUS, 32'h03);
    rdchk("flag_ro", OFF_CTRL_TWO, 32'h0);
    rdchk("unmapped", 8'h10, 32'h0);
    for (int i = 0; i < 40; i++) begin
      c1 = (i < 4) ? tbl[i] : 8'($urandom) & 8'h43;
      sel = (i % 2 == 1) ? 8'($urandom_range(255, 1)) : 8'h00;
      apply(c1, sel);
    end
    // Events outside an operation must not count
    apply(8'h40, 8'h0F);
    cpu.pulse(5'h1F);
    #1;
    chk("idle_event", 32'h0, {31'h0, err_flag});
    for (int k = 0; k < 5; k++) begin
      apply((k % 2 == 1) ? 8'h42 : 8'h41, 8'($urandom_range(255, 1)));
      cpu.pulse(prot_event_t'(5'h01 << k));
      #1;
      chk("abort", 32'h1, {29'h0, prog_q, erase_q, err_flag});
      rdchk("flag", OFF_CTRL_TWO, 32'h80);
      fl_e = 1'b1;
      apply(8'h41, 8'hFF);
      @(posedge hclk);
      power_entry <= (k % 2 == 1) ? 2'b01 : 2'b10;
      @(posedge hclk);
      power_entry <= 2'b00;
      settle();
      fl_e = 1'b0;
      chk("flag_clr", 32'h0, {31'h0, err_flag});
      regs_clear();
      apply(8'h41, 8'h01);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      #1;
      chk("rst_abort", 32'h0, {29'h0, prog_q, erase_q, err_flag});
      @(posedge hclk);
      hresetn <= 1'b1;
      regs_clear();
    end
    stop_test();
  end
endmodule
